// >>> rtl/fsr_cfg.svh
// Constants for the seek, recalibrate and interrupt-status block
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH
`define FSR_CLK_HZ        100000000
`define FSR_REF_HZ        16000000
`define FSR_REF_CLK_MHZ   16
`define FSR_SYS_CLK_MHZ   100
`define FSR_TICK_US       1000
`define FSR_RECAL_LIMIT   8'd77
`define FSR_DIR_IN        1'b1
`define FSR_DIR_OUT       1'b0
`define FSR_STEP_LOW_CYC  8'd24
`define FSR_SRT_MAX       4'hf
`define FSR_HUT_UNIT      5'd16
`define FSR_HLT_UNIT      8'd2
`define FSR_IC_NORMAL     2'b00
`define FSR_IC_ABNORMAL   2'b01
`define FSR_IC_INVALID    2'b10
`define FSR_IC_READY      2'b11
`define FSR_ST0_INVALID   8'h80
`define FSR_CMD_SEEK      3'h1
`define FSR_CMD_RECAL     3'h2
`define FSR_CMD_SENSE     3'h3
`define FSR_CMD_OTHER     3'h4
`define FSR_CMD_BAD       3'h5
`endif

// >>> rtl/fsr_pkg.sv
// Types for the seek, recalibrate and interrupt-status block
package fsr_pkg;
   typedef struct packed {
      logic       valid;
      logic [2:0] op;
      logic [1:0] drive;
      logic [7:0] target_cylinder;
   } fsr_cmd_t;
   typedef struct packed {
      logic       request_for_master_flag;
      logic       transfer_direction_flag;
      logic       execution_phase_flag;
      logic       busy;
      logic [3:0] drive_seeking_bits;
   } fsr_msr_t;
   typedef enum logic [2:0] {
      FSR_IDLE  = 3'b001,
      FSR_PULSE = 3'b010,
      FSR_WAIT  = 3'b100
   } fsr_step_t;
endpackage

// >>> rtl/fsr_seek.sv
// Seek, recalibrate, timer and interrupt-status logic of a disk controller
//
// Functional notes
// - Four present-cylinder registers; only recalibrate clears one.
// - Present below target: direction high, then step pulses.
// - Present above target: direction low, then step pulses.
// - Steps spaced by step interval; match sets seek-done, ends, interrupts.
// - Per-drive seeking bit set during seek until sense-interrupt clears it.
// - Busy only while command accepted, so four drives may seek at once.
// - Slow command entry may shorten first step gap by up to 1 ms.
// - Recalibrate clears cylinder; steps outward while track-zero is low.
// - Track-zero high during recalibrate sets seek-done and ends command.
// - 77 steps without track-zero: seek-done, fault, abnormal code, end.
// - Recalibrates overlap across drives like seeks.
// - Interrupt on result phase, ready change, seek end, non-DMA transfer.
// - Non-DMA execution flag high, cleared at result; data access clears interrupt.
// - Sense-interrupt clears interrupt, reports cause in status-zero bits 7..5.
// - Unload delay code selects 16 to 240 ms in 16 ms steps.
// - Step interval code inverse: F is 1 ms, E is 2 ms, up to 16.
// - Load delay code selects 2 to 254 ms in 2 ms steps.
// - Timer intervals scale inversely with the controller reference clock.
// - No-DMA select high chooses non-DMA mode, low chooses DMA.
// - Undefined command: status zero 80 hex, no interrupt, direction and request high.
// - Missing sense-interrupt after seek end makes next command invalid.
`timescale 1ns/1ps
`include "fsr_cfg.svh"

module fsr_seek #(
   parameter int REF_MHZ = `FSR_REF_CLK_MHZ,
   parameter int SYS_MHZ = `FSR_SYS_CLK_MHZ
) (
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire fsr_pkg::fsr_cmd_t cmd,
   input  wire logic [3:0]      step_interval_code,
   input  wire logic [3:0]      unload_delay_code,
   input  wire logic [6:0]      load_delay_code,
   input  wire logic            no_dma_select,
   input  wire logic            track_zero,
   input  wire logic [3:0]      drive_ready,
   input  wire logic            exec_start,
   input  wire logic            result_enter,
   input  wire logic            data_access,
   input  wire logic            head_load_start,
   input  wire logic            unload_start,
   input  wire logic            st0_read,
   output logic                 step_n,
   output logic                 direction,
   output logic [1:0]           drive_select,
   output logic                 head_loaded,
   output logic                 load_done,
   output logic                 irq,
   output logic [7:0]           status_zero,
   output logic [7:0]           present_cylinder_0,
   output fsr_pkg::fsr_msr_t    main_status
);
   import fsr_pkg::*;

   // Ticks per ms of the reference clock, scaled to our clock
   localparam int TICK_CYC = (`FSR_TICK_US * SYS_MHZ * `FSR_REF_CLK_MHZ) / REF_MHZ;
   localparam logic [16:0] TICK_LAST = 17'(TICK_CYC - 1);

   logic [16:0] tick_cnt_r;
   logic        ms_tick;
   logic [7:0]  pcn_r [4];
   logic [7:0]  ncn_r [4];
   logic [3:0]  active_r;
   logic [3:0]  recal_r;
   logic [3:0]  done_r;
   logic [1:0]  code_r [4];
   logic [7:0]  recal_cnt_r [4];
   logic [3:0]  seeking_r;
   fsr_step_t   st_r;
   logic [1:0]  cur_r;
   logic [7:0]  pulse_r;
   logic [4:0]  gap_r;
   logic [3:0]  ready_r;
   logic        ready_irq_r;
   logic        xfer_irq_r;
   logic        exec_r;
   logic        invalid_r;
   logic [7:0]  st0_r;
   logic        busy_r;
   logic        sense_pending;
   logic        ready_ok_r;
   logic        sel_ok;
   logic        cmd_bad;
   logic [1:0]  pick;
   logic        pick_ok;
   logic [8:0]  hut_r;
   logic [7:0]  hlt_r;

   ////////////////////////////////////////////////////////////////
   // Millisecond enable, referenced to a 16 MHz part clock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_cnt_r <= 17'h0;
      end else if (tick_cnt_r == TICK_LAST) begin
         tick_cnt_r <= 17'h0;
      end else begin
         tick_cnt_r <= tick_cnt_r + 17'h1;
      end
   end
   assign ms_tick = (tick_cnt_r == TICK_LAST);

   // An unanswered seek end poisons the next non-sense command
   assign sense_pending = (done_r != 4'h0);
   assign cmd_bad = cmd.valid && ((cmd.op == `FSR_CMD_BAD)
                    || (sense_pending && cmd.op != `FSR_CMD_SENSE));

   ////////////////////////////////////////////////////////////////
   // Per-drive positioning state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) begin
            pcn_r[i]       <= 8'h0;
            ncn_r[i]       <= 8'h0;
            code_r[i]      <= `FSR_IC_NORMAL;
            recal_cnt_r[i] <= 8'h0;
         end
         active_r  <= 4'h0;
         recal_r   <= 4'h0;
         done_r    <= 4'h0;
         seeking_r <= 4'h0;
      end else begin
         // Several drives may run at once: busy drops once taken
         if (cmd.valid && !cmd_bad && cmd.op == `FSR_CMD_SEEK) begin
            ncn_r[cmd.drive]     <= cmd.target_cylinder;
            active_r[cmd.drive]  <= 1'b1;
            recal_r[cmd.drive]   <= 1'b0;
            seeking_r[cmd.drive] <= 1'b1;
         end
         if (cmd.valid && !cmd_bad && cmd.op == `FSR_CMD_RECAL) begin
            pcn_r[cmd.drive]       <= 8'h0;
            ncn_r[cmd.drive]       <= 8'h0;
            recal_cnt_r[cmd.drive] <= 8'h0;
            active_r[cmd.drive]    <= 1'b1;
            recal_r[cmd.drive]     <= 1'b1;
            seeking_r[cmd.drive]   <= 1'b1;
         end
         // Sense clears one finished drive; placed first so a drive that
         // finishes in the same cycle keeps its flag
         if (cmd.valid && cmd.op == `FSR_CMD_SENSE && !ready_irq_r && done_r != 4'h0) begin
            for (int i = 3; i >= 0; i--) begin
               if (done_r[i]) begin
                  done_r    <= done_r & ~(4'h1 << i);
                  seeking_r <= seeking_r & ~(4'h1 << i);
               end
            end
         end
         // Completion check at the start of each drive's turn
         if (st_r == FSR_IDLE && sel_ok) begin
            if (recal_r[pick] && track_zero) begin
               active_r[pick] <= 1'b0;
               done_r[pick]   <= 1'b1;
               code_r[pick]   <= `FSR_IC_NORMAL;
            end else if (recal_r[pick] && recal_cnt_r[pick] == `FSR_RECAL_LIMIT) begin
               active_r[pick] <= 1'b0;
               done_r[pick]   <= 1'b1;
               code_r[pick]   <= `FSR_IC_ABNORMAL;
            end else if (!recal_r[pick] && pcn_r[pick] == ncn_r[pick]) begin
               active_r[pick] <= 1'b0;
               done_r[pick]   <= 1'b1;
               code_r[pick]   <= `FSR_IC_NORMAL;
            end
         end
         // Cylinder follows each pulse; recalibrate only counts
         if (st_r == FSR_PULSE && pulse_r == 8'h0) begin
            if (recal_r[cur_r]) begin
               recal_cnt_r[cur_r] <= recal_cnt_r[cur_r] + 8'h1;
            end else if (direction == `FSR_DIR_IN) begin
               pcn_r[cur_r] <= pcn_r[cur_r] + 8'h1;
            end else begin
               pcn_r[cur_r] <= pcn_r[cur_r] - 8'h1;
            end
         end
      end
   end

   // Lowest-numbered active drive gets the stepper next
   always_comb begin
      pick    = 2'd0;
      pick_ok = 1'b0;
      for (int i = 3; i >= 0; i--) begin
         if (active_r[i]) begin
            pick    = 2'(i);
            pick_ok = 1'b1;
         end
      end
   end
   // Picked drive is the one already on the select lines
   assign sel_ok = pick_ok && (cur_r == pick);

   ////////////////////////////////////////////////////////////////
   // Step generator: pulse then programmed gap; gap is counted in
   // whole ms ticks, so the first gap may run short by under 1 ms
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r      <= FSR_IDLE;
         cur_r     <= 2'd0;
         pulse_r   <= 8'h0;
         gap_r     <= 5'h0;
         direction <= `FSR_DIR_OUT;
         step_n    <= 1'b1;
      end else begin
         case (st_r)
            FSR_IDLE: begin
               // Select the drive a cycle ahead so track-zero belongs to it
               if (pick_ok && !sel_ok) begin
                  cur_r <= pick;
               end else if (sel_ok && !(recal_r[pick] && (track_zero || recal_cnt_r[pick] == `FSR_RECAL_LIMIT))
                   && !(!recal_r[pick] && pcn_r[pick] == ncn_r[pick])) begin
                  // Direction settles before the pulse goes low
                  if (!recal_r[pick] && pcn_r[pick] < ncn_r[pick]) begin
                     direction <= `FSR_DIR_IN;
                  end else begin
                     direction <= `FSR_DIR_OUT;
                  end
                  pulse_r <= `FSR_STEP_LOW_CYC;
                  st_r    <= FSR_PULSE;
               end
            end
            FSR_PULSE: begin
               step_n <= (pulse_r == 8'h0);
               if (pulse_r == 8'h0) begin
                  gap_r <= 5'(`FSR_SRT_MAX - step_interval_code) + 5'h1;
                  st_r  <= FSR_WAIT;
               end else begin
                  pulse_r <= pulse_r - 8'h1;
               end
            end
            FSR_WAIT: begin
               if (ms_tick) begin
                  if (gap_r == 5'h1) begin
                     st_r <= FSR_IDLE;
                  end
                  gap_r <= gap_r - 5'h1;
               end
            end
            default: st_r <= FSR_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Interrupt sources and status zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ready_r         <= 4'h0;
         ready_irq_r     <= 1'b0;
         xfer_irq_r      <= 1'b0;
         exec_r          <= 1'b0;
         invalid_r       <= 1'b0;
         st0_r           <= 8'h0;
         busy_r          <= 1'b0;
         ready_ok_r      <= 1'b0;
      end else begin
         ready_r <= drive_ready;
         ready_ok_r <= 1'b1;
         busy_r  <= cmd.valid;
         if (exec_start && no_dma_select) begin
            exec_r <= 1'b1;
         end else if (result_enter) begin
            exec_r <= 1'b0;
         end
         // Result entry wins over a clearing access; a pending non-DMA transfer cause does not
         if (result_enter || (exec_r && no_dma_select && !data_access)) begin
            xfer_irq_r <= 1'b1;
         end else if (data_access) begin
            xfer_irq_r <= 1'b0;
         end
         // No false change right after reset: wait for a held sample
         if (ready_ok_r && ready_r != drive_ready) begin
            ready_irq_r <= 1'b1;
         end else if (cmd.valid && cmd.op == `FSR_CMD_SENSE) begin
            ready_irq_r <= 1'b0;
         end
         if (cmd_bad) begin
            st0_r     <= `FSR_ST0_INVALID;
            invalid_r <= 1'b1;
         end else if (cmd.valid && cmd.op == `FSR_CMD_SENSE) begin
            if (ready_irq_r) begin
               st0_r <= {`FSR_IC_READY, 1'b0, 5'h0};
            end else begin
               for (int i = 3; i >= 0; i--) begin
                  if (done_r[i]) begin
                     st0_r <= {code_r[i], 1'b1, code_r[i] == `FSR_IC_ABNORMAL, 2'h0, 2'(i)};
                  end
               end
            end
         end
         // A fresh refusal wins over the read that clears the last one
         if (st0_read && !cmd_bad) begin
            invalid_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Head unload and head load timers in ms ticks
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hut_r       <= 9'h0;
         hlt_r       <= 8'h0;
         head_loaded <= 1'b0;
         load_done   <= 1'b0;
      end else begin
         if (head_load_start) begin
            head_loaded <= 1'b1;
            // Spare tick: a partial first ms must never make the load short
            hlt_r       <= 8'(load_delay_code) * `FSR_HLT_UNIT + 8'h1;
            load_done   <= 1'b0;
         end else if (ms_tick && hlt_r != 8'h0) begin
            hlt_r <= hlt_r - 8'h1;
         end else if (head_loaded && hlt_r == 8'h0) begin
            load_done <= 1'b1;
         end
         if (unload_start) begin
            hut_r <= 9'(unload_delay_code) * 9'(`FSR_HUT_UNIT);
         end else if (ms_tick && hut_r != 9'h0) begin
            hut_r <= hut_r - 9'h1;
            if (hut_r == 9'h1) begin
               head_loaded <= 1'b0;
            end
         end
      end
   end

   // Invalid command never interrupts; only real events do
   assign irq = xfer_irq_r || ready_irq_r || (done_r != 4'h0);
   assign status_zero        = st0_r;
   assign present_cylinder_0 = pcn_r[0];
   assign drive_select       = cur_r;
   assign main_status.request_for_master_flag = !busy_r || invalid_r;
   assign main_status.transfer_direction_flag = invalid_r;
   assign main_status.execution_phase_flag    = exec_r;
   assign main_status.busy                    = busy_r || invalid_r;
   assign main_status.drive_seeking_bits      = seeking_r;
endmodule

// >>> bench/fsr_seek_chk.sv
// Port-level assertions for the seek and interrupt block
`timescale 1ns/1ps
`include "fsr_cfg.svh"
module fsr_seek_chk (
   input wire logic              clk,
   input wire logic              rst,
   input wire fsr_pkg::fsr_cmd_t cmd,
   input wire logic [3:0]        drive_ready,
   input wire logic              result_enter,
   input wire logic              step_n,
   input wire logic              direction,
   input wire logic              irq,
   input wire logic [7:0]        status_zero,
   input wire fsr_pkg::fsr_msr_t main_status
);
   import fsr_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   // Step pulse low for its first 8 cycles and its 24th, high on the 25th
   property p_step_width;
      $fell(step_n) |-> (!step_n)[*8] ##16 !step_n ##1 step_n;
   endproperty
   a_step_width: assert property (p_step_width) else $error("step width wrong");
   // Direction may not move under a step pulse
   property p_dir_hold;
      !step_n |-> $stable(direction);
   endproperty
   a_dir_hold: assert property (p_dir_hold) else $error("direction moved in step");
   // Busy only in the command phase, so more seeks get in
   property p_busy;
      cmd.valid && cmd.op == `FSR_CMD_SEEK |=> main_status.busy ##[1:8] !main_status.busy;
   endproperty
   a_busy: assert property (p_busy) else $error("busy not brief");
   property p_seek_mark;
      cmd.valid && cmd.op == `FSR_CMD_SEEK |=> main_status.drive_seeking_bits[$past(cmd.drive)];
   endproperty
   a_seek_mark: assert property (p_seek_mark) else $error("seeking bit not set");
   // With one cause left a sense drops the interrupt
   property p_sense;
      cmd.valid && cmd.op == `FSR_CMD_SENSE && $onehot0(main_status.drive_seeking_bits) |-> ##[1:3] !irq;
   endproperty
   a_sense: assert property (p_sense) else $error("sense left irq high");
   property p_bad_quiet;
      cmd.valid && cmd.op == `FSR_CMD_BAD && !irq |=> (!irq)[*4];
   endproperty
   a_bad_quiet: assert property (p_bad_quiet) else $error("undefined command raised irq");
   property p_bad_st0;
      cmd.valid && cmd.op == `FSR_CMD_BAD |-> ##[1:3] status_zero == 8'h80
         && main_status.transfer_direction_flag && main_status.request_for_master_flag;
   endproperty
   a_bad_st0: assert property (p_bad_st0) else $error("undefined command status wrong");
   property p_result;
      result_enter |=> !main_status.execution_phase_flag;
   endproperty
   a_result: assert property (p_result) else $error("exec flag kept in result");
   property p_ready;
      $changed(drive_ready) |-> ##[1:3] irq;
   endproperty
   a_ready: assert property (p_ready) else $error("ready change without irq");
endmodule
bind fsr_seek fsr_seek_chk fsr_seek_chk_inst (.clk, .rst, .cmd, .drive_ready, .result_enter,
   .step_n, .direction, .irq, .status_zero, .main_status);

// >>> bench/fsr_drive_model.sv
// Behavioural drive stack answering step pulses with a track-zero level
`timescale 1ns/1ps
module fsr_drive_model #(
   parameter int POS1 = 200
) (
   input  wire logic       step_n,
   input  wire logic       direction,
   input  wire logic [1:0] drive_select,
   output logic            track_zero
);
   int pos [4] = '{0, POS1, 0, 0};
   // Head moves at the leading edge; the stop at track zero is mechanical
   always @(negedge step_n) begin
      if (direction) begin
         pos[drive_select] = pos[drive_select] + 1;
      end else if (pos[drive_select] > 0) begin
         pos[drive_select] = pos[drive_select] - 1;
      end
   end
   // Only the drive being stepped reports its track
   assign track_zero = (pos[drive_select] == 0);
endmodule

// >>> bench/floppy_seek_recal_interrupt_tb.sv
// Directed testbench for the seek, recalibrate and interrupt block
`timescale 1ns/1ps
module floppy_seek_recal_interrupt_tb;
   import fsr_pkg::*;
   localparam int MS = 500;   // Cycles per ms with a 32 MHz reference at SYS 1
   logic       clk, rst, nds, tz, step_n, dir, hl, ld, irq;
   logic [3:0] sic, udc, rdy;
   logic [6:0] ldc;
   logic [5:0] pl;
   logic [1:0] dsel;
   logic [7:0] st0, cyl0;
   fsr_cmd_t   cmd;
   fsr_msr_t   msr;
   int         bad_count = 0, compares = 0, steps = 0, cyc = 0, t0 = 0, t1 = 0, n;
   fsr_seek #(.REF_MHZ(32), .SYS_MHZ(1)) fsr_seek_inst (.clk(clk), .rst(rst), .cmd(cmd),
      .step_interval_code(sic), .unload_delay_code(udc), .load_delay_code(ldc), .no_dma_select(nds),
      .track_zero(tz), .drive_ready(rdy), .exec_start(pl[0]), .result_enter(pl[1]),
      .data_access(pl[2]), .head_load_start(pl[3]), .unload_start(pl[4]), .st0_read(pl[5]),
      .step_n(step_n), .direction(dir), .drive_select(dsel), .head_loaded(hl), .load_done(ld),
      .irq(irq), .status_zero(st0), .present_cylinder_0(cyl0), .main_status(msr));
   fsr_drive_model fsr_drive_model_inst (.step_n(step_n), .direction(dir), .drive_select(dsel),
      .track_zero(tz));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   // Count steps and keep the time of the last two
   always @(negedge step_n) begin
      steps++;
      t0 = t1;
      t1 = cyc;
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic send(logic [2:0] op, logic [1:0] drv, logic [7:0] tgt);
      @(negedge clk) cmd = '{1'b1, op, drv, tgt};
      @(negedge clk) cmd.valid = 1'b0;
   endtask
   task automatic pulse(int i);
      @(negedge clk) pl[i] = 1'b1;
      @(negedge clk) pl = '0;
   endtask
   // Bounded wait; running out shows as an irq mismatch
   task automatic wait_irq();
      for (n = 0; n < 60000 && irq !== 1'b1; n++) @(negedge clk);
      chk("irq", 8'(irq), 8'h1);
   endtask
   task automatic sense(logic [7:0] exp, logic [7:0] mask);
      send(3'h3, 2'd0, 8'h00);
      repeat (2) @(negedge clk);
      chk("st0", st0 & mask, exp);
   endtask
   task automatic give_verdict();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      bad_count++;
      give_verdict();
   end
   ////////////////////////////////////////////////////////////
   initial begin
      cmd = '0;
      {sic, udc, ldc, nds, rdy, pl} = {4'he, 4'h1, 7'h02, 1'b0, 4'hf, 6'h00};
      rst = 1'b1;
      repeat (8) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      chk("msr", msr, 8'h80);
      // Seek in by three; last gap is free of the slow-entry allowance
      steps = 0;
      send(3'h1, 2'd0, 8'h03);
      chk("busy", 8'(msr[4:0]), 8'h11);
      // Direction is driven one edge after the command is taken
      @(negedge clk);
      chk("dir", 8'(dir), 8'h1);
      wait_irq();
      chk("steps", 8'(steps), 8'h3);
      chk("cyl", cyl0, 8'h03);
      chk("gap", 8'((t1 - t0 + 20) / 50), 8'(2 * MS / 50));
      sense(8'h20, 8'hff);
      chk("seeking", 8'(msr[3:0]), 8'h0);
      sic = 4'hf;
      send(3'h1, 2'd0, 8'h01);
      @(negedge clk);
      chk("dir", 8'(dir), 8'h0);
      wait_irq();
      chk("cyl", cyl0, 8'h01);
      sense(8'h20, 8'hff);
      // Recalibrate meets track zero after one step
      steps = 0;
      send(3'h2, 2'd0, 8'h00);
      wait_irq();
      chk("steps", 8'(steps), 8'h1);
      chk("cyl", cyl0, 8'h00);
      sense(8'h20, 8'hff);
      // Drive one never reaches track zero
      steps = 0;
      send(3'h2, 2'd1, 8'h00);
      wait_irq();
      chk("steps", 8'(steps), 8'd77);
      chk("dsel", 8'(dsel), 8'h1);
      sense(8'h71, 8'hff);
      // Two drives seek at once, lower drive reported first
      send(3'h1, 2'd0, 8'h02);
      send(3'h1, 2'd2, 8'h01);
      chk("both", 8'(msr[3:0]), 8'h5);
      wait_irq();
      // Host holds its sense until every drive has stopped stepping
      repeat (2 * MS) @(negedge clk);
      sense(8'h20, 8'hff);
      wait_irq();
      sense(8'h22, 8'hff);
      // A command after an unsensed seek end is refused
      send(3'h1, 2'd0, 8'h03);
      wait_irq();
      send(3'h4, 2'd0, 8'h00);
      repeat (2) @(negedge clk);
      chk("st0", st0, 8'h80);
      chk("msr", 8'(msr[7:6]), 8'h3);
      pulse(5);
      sense(8'h20, 8'hff);
      send(3'h5, 2'd0, 8'h00);
      repeat (2) @(negedge clk);
      chk("st0", st0, 8'h80);
      chk("irq", 8'(irq), 8'h0);
      pulse(5);
      // Ready change is a sensed cause
      rdy = 4'h7;
      wait_irq();
      sense(8'hc0, 8'he0);
      // Non-DMA transfer, then DMA where the exec flag stays low
      nds = 1'b1;
      pulse(0);
      chk("exec", 8'(msr.execution_phase_flag), 8'h1);
      @(negedge clk);
      chk("irq", 8'(irq), 8'h1);
      pulse(2);
      chk("irq", 8'(irq), 8'h0);
      pulse(1);
      chk("exec", 8'(msr.execution_phase_flag), 8'h0);
      chk("irq", 8'(irq), 8'h1);
      pulse(2);
      nds = 1'b0;
      pulse(0);
      chk("exec", 8'(msr.execution_phase_flag), 8'h0);
      pulse(1);
      pulse(2);
      // Head load code 2 gives 4 ms on the scaled clock
      n = cyc;
      pulse(3);
      while (ld !== 1'b1 && cyc - n < 6 * MS) @(negedge clk);
      chk("load_min", 8'(cyc - n >= 4 * MS), 8'h1);
      chk("load_max", 8'(cyc - n <= 5 * MS + 20), 8'h1);
      chk("head", 8'(hl), 8'h1);
      // Unload code 1 is 16 ms; its first ms may be partial
      pulse(4);
      repeat (14 * MS) @(negedge clk);
      chk("unload_hold", 8'(hl), 8'h1);
      repeat (2 * MS + 20) @(negedge clk);
      chk("unload", 8'(hl), 8'h0);
      give_verdict();
   end
endmodule
